// ===== dv/host_model.sv
// host side model driving the register port
`timescale 1ns/1ps
module host_model
(
  // clock
  input  wire logic        mclk,
  // register port
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one address per access, data beside it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ===== dv/voice_gate_peak_and_store_bench.sv
// bench: registers, peak meter and speech store
`timescale 1ns/1ps
module voice_gate_peak_and_store_bench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] mic_sample = 16'h0000;
  logic        mic_valid = 1'b0;
  logic        play_req = 1'b0;
  logic [15:0] rec_frame = 16'h0000;
  logic        rec_valid = 1'b0;
  logic [15:0] play_frame;
  logic        play_valid;
  logic [15:0] enc_sample;
  logic        enc_valid;
  logic [15:0] spk_sample;
  logic        spk_valid;
  logic        irq;
  logic [15:0] v;
  logic [15:0] x;
  logic [15:0] fr [3];
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          nv = 0;
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  host_model i_host_model (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  voice_gate_peak_and_store i_voice_gate_peak_and_store (.mclk(mclk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mic_sample(mic_sample), .mic_valid(mic_valid),
    .enc_sample(enc_sample), .enc_valid(enc_valid),
    .dec_sample(mic_sample), .dec_valid(mic_valid),
    .spk_sample(spk_sample), .spk_valid(spk_valid), .rec_frame(rec_frame),
    .rec_valid(rec_valid), .play_req(play_req), .play_frame(play_frame),
    .play_valid(play_valid), .irq(irq));
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // loud half then half-level half: unity dc gain keeps the peak at x,
  // so a meter that kept the last sample would fail
  task automatic feed_frame;
    for (int i = 0; i < 160; i++)
    begin
      @(posedge mclk);
      mic_valid <= 1'b1;
      mic_sample <= (i < 80) ? x : x >> 1;
      @(posedge mclk);
      mic_valid <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask
  task automatic take(input logic [15:0] e);
    @(posedge mclk);
    play_req <= 1'b1;
    @(posedge mclk);
    play_req <= 1'b0;
    #1;
    chk("play_valid", {15'h0000, play_valid}, 16'h0001);
    chk("play_frame", play_frame, e);
  endtask
  task automatic rec_one(input logic [15:0] f);
    @(posedge mclk);
    rec_valid <= 1'b1;
    rec_frame <= f;
    @(posedge mclk);
    rec_valid <= 1'b0;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    nv <= nv + enc_valid + spk_valid;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(32'h0443ed0c));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    i_host_model.rd(8'h04, v);
    chk("upper", v, 16'h0800);
    i_host_model.rd(8'h05, v);
    chk("lower", v, 16'h0400);
    i_host_model.rd(8'h07, v);
    chk("delay", v, 16'h0008);
    i_host_model.rd(8'h20, v);
    chk("unmapped", v, 16'h0000);
    x = 16'($urandom_range(16'h3FFF, 16'h0100));
    i_host_model.wr(8'h04, x);
    i_host_model.rd(8'h04, v);
    chk("upper", v, x);
    feed_frame();
    i_host_model.rd(8'h03, v);
    chk("peak off", v, 16'h0000);
    i_host_model.wr(8'h02, 16'h0001);
    i_host_model.wr(8'h01, 16'h0005);
    feed_frame();
    i_host_model.rd(8'h03, v);
    chk("peak", v, x);
    chk("enc open", enc_sample, x >> 1);
    chk("spk", spk_sample, x >> 1);
    i_host_model.wr(8'h05, 16'h7FFF);
    i_host_model.wr(8'h07, 16'h0000);
    x = 16'h0040;
    repeat (3) feed_frame();
    chk("enc fade", enc_sample, 16'h0010);
    i_host_model.wr(8'h06, 16'h0001);
    i_host_model.rd(8'h06, v);
    chk("mute", v, 16'h0001);
    i_host_model.wr(8'h08, 16'h6200);
    for (int i = 0; i < 3; i++)
    begin
      fr[i] = 16'($urandom);
      rec_one(fr[i]);
    end
    i_host_model.wr(8'h08, 16'h7000);
    i_host_model.wr(8'h08, 16'hA200);
    i_host_model.rd(8'h09, v);
    chk("length", v, 16'd3);
    i_host_model.wr(8'h08, 16'h9000);
    i_host_model.rd(8'h09, v);
    chk("free", v, 16'd960);
    i_host_model.wr(8'h08, 16'h3200);
    take(fr[0]);
    i_host_model.wr(8'h08, 16'h4000);
    i_host_model.wr(8'h08, 16'h5000);
    take(fr[1]);
    i_host_model.wr(8'h08, 16'h8001);
    take(fr[1]);
    i_host_model.wr(8'h08, 16'hB000);
    i_host_model.rd(8'h09, v);
    chk("state", v, 16'd2);
    // 24 free blocks take 960 frames; the next one finds none
    i_host_model.wr(8'h08, 16'h6400);
    repeat (961) rec_one(16'($urandom));
    i_host_model.rd(8'h0A, v);
    chk("status", v, 16'h0003);
    chk("irq off", {15'h0000, irq}, 16'h0000);
    i_host_model.wr(8'h0B, 16'h0001);
    i_host_model.wr(8'h08, 16'h9000);
    i_host_model.rd(8'h09, v);
    chk("free", v, 16'h0000);
    chk("irq", {15'h0000, irq}, 16'h0001);
    chk("valids", 16'(nv), 16'h0640);
    wrap_up();
  end
endmodule

// ===== logic/frame_if.sv
// sample stream and per-frame level between meter and gate
`timescale 1ns/1ps
interface frame_if;
  logic [15:0] sample;
  logic        valid;
  logic [15:0] level;
  logic        frame_done;
  modport meter (input sample, input valid, output level, output frame_done);
  modport gate  (input sample, input valid, input level, input frame_done);
endinterface

// ===== logic/noise_gate.sv
// hysteretic noise gate with shut delay and stepped fade
`timescale 1ns/1ps
`include "vgps_consts.svh"
module noise_gate
  import vgps_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // frame stream
  frame_if.gate            fi,
  // settings
  input  wire logic [15:0] upper,
  input  wire logic [15:0] lower,
  input  wire logic        mute,
  input  wire logic [7:0]  shut_delay,
  // gated samples
  output logic      [15:0] out_sample,
  output logic             out_valid
);
  gate_state_e st_reg, st_next;
  logic [7:0]  hold_reg, hold_next;
  logic [4:0]  att_reg, att_next;
  logic [15:0] out_reg, out_next;
  logic        ov_reg, ov_next;
  logic [8:0]  hold_inc;

  // one frame of latency: the level is judged after the frame it measures
  always_comb
  begin
    st_next = st_reg;
    hold_next = hold_reg;
    att_next = att_reg;
    out_next = out_reg;
    ov_next = fi.valid;
    hold_inc = {1'b0, hold_reg} + 9'h001;
    if (fi.valid)
    begin
      if (mute || att_reg >= `FADE_FRAMES)
        out_next = 16'h0000;
      else
        out_next = 16'($signed(fi.sample) >>> att_reg);
    end
    if (fi.frame_done)
    begin
      if (fi.level >= upper)
      begin
        st_next = G_OPEN;
        hold_next = 8'h00;
        att_next = 5'h00;
      end
      else
      begin
        case (st_reg)
          G_OPEN, G_HOLD:
            if (fi.level < lower)
            begin
              hold_next = hold_inc[7:0];
              if (hold_inc >= {1'b0, shut_delay})
                st_next = G_FADE;
              else
                st_next = G_HOLD;
            end
            else
            begin
              hold_next = 8'h00;
              st_next = G_OPEN;
            end
          G_FADE:
          begin
            att_next = att_reg + 5'h01;
            if (att_reg == `FADE_FRAMES - 5'h01)
              st_next = G_SHUT;
          end
          G_SHUT:
            st_next = G_SHUT;
          default:
            st_next = G_SHUT;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= G_SHUT;
      hold_reg <= 8'h00;
      att_reg <= `FADE_FRAMES;
      out_reg <= 16'h0000;
      ov_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      hold_reg <= hold_next;
      att_reg <= att_next;
      out_reg <= out_next;
      ov_reg <= ov_next;
    end
  end

  assign out_sample = out_reg;
  assign out_valid = ov_reg;

  property p_reopen;
    @(posedge mclk) disable iff (rst)
      (fi.frame_done && fi.level >= upper)
        |=> (st_reg == G_OPEN && att_reg == 5'h00);
  endproperty
  a_reopen: assert property (p_reopen)
    else $error("gate did not reopen at upper threshold");

  property p_fade_step;
    @(posedge mclk) disable iff (rst)
      (fi.frame_done && st_reg == G_FADE && fi.level < upper)
        |=> att_reg == $past(att_reg) + 5'h01;
  endproperty
  a_fade_step: assert property (p_fade_step)
    else $error("fade did not step one level per frame");

  property p_hold_restart;
    @(posedge mclk) disable iff (rst)
      (fi.frame_done && st_reg == G_HOLD && fi.level >= lower)
        |=> (hold_reg == 8'h00 && st_reg == G_OPEN);
  endproperty
  a_hold_restart: assert property (p_hold_restart)
    else $error("shut delay not restarted by loud frame");
endmodule

// ===== logic/peak_meter.sv
// per-frame peak magnitude meter
`timescale 1ns/1ps
`include "vgps_consts.svh"
module peak_meter
  import vgps_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // control
  input  wire logic        enable,
  // frame stream
  frame_if.meter           fi,
  // result
  output logic      [15:0] peak_result
);
  logic [7:0]  cnt_reg, cnt_next;
  logic [15:0] max_reg, max_next;
  logic [15:0] lvl_reg, lvl_next;
  logic [15:0] res_reg, res_next;
  logic        done_reg, done_next;
  logic [15:0] mag;
  logic [15:0] top;

  // framing runs even when off, since the gate needs a level every frame
  always_comb
  begin
    mag = fi.sample[15] ? 16'(-fi.sample) : fi.sample;
    top = (mag > max_reg) ? mag : max_reg;
    cnt_next = cnt_reg;
    max_next = max_reg;
    lvl_next = lvl_reg;
    res_next = res_reg;
    done_next = 1'b0;
    if (fi.valid)
    begin
      if (cnt_reg == `FRAME_SAMPLES - 8'h01)
      begin
        cnt_next = 8'h00;
        max_next = 16'h0000;
        lvl_next = top;
        done_next = 1'b1;
        if (enable)
          res_next = top;
      end
      else
      begin
        cnt_next = cnt_reg + 8'h01;
        max_next = top;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 8'h00;
      max_reg <= 16'h0000;
      lvl_reg <= 16'h0000;
      res_reg <= 16'h0000;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      max_reg <= max_next;
      lvl_reg <= lvl_next;
      res_reg <= res_next;
      done_reg <= done_next;
    end
  end

  assign fi.level = lvl_reg;
  assign fi.frame_done = done_reg;
  assign peak_result = res_reg;

  property p_peak_frozen;
    @(posedge mclk) disable iff (rst)
      (fi.valid && !enable) |=> $stable(res_reg);
  endproperty
  a_peak_frozen: assert property (p_peak_frozen)
    else $error("peak result changed while meter off");

  property p_frame_len;
    @(posedge mclk) disable iff (rst)
      (fi.valid && cnt_reg == `FRAME_SAMPLES - 8'h01)
        |=> (done_reg && cnt_reg == 8'h00);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame did not close after its last sample");
endmodule

// ===== logic/vgps_consts.svh
// offsets, fields, reset values and counts of the voice gate and store
`ifndef VGPS_CONSTS_SVH
`define VGPS_CONSTS_SVH
`define FRAME_SAMPLES 8'hA0
`define FADE_FRAMES   5'h10
`define BLK_FRAMES    6'h28
`define NUM_BLKS      25
`define NUM_BUFS      8
`define MEM_WORDS     1000
`define FIR_TAPS      8
`define FIR_COEFS     64'h0102040909040201
`define FIR_SHIFT     5
`define OFS_CTRL      8'h01
`define OFS_PKSW      8'h02
`define OFS_PEAK      8'h03
`define OFS_UPPER     8'h04
`define OFS_LOWER     8'h05
`define OFS_MUTE      8'h06
`define OFS_DELAY     8'h07
`define OFS_CMD       8'h08
`define OFS_RESP      8'h09
`define OFS_STATUS    8'h0A
`define OFS_IEN       8'h0B
`define CTRL_PEAK_BIT 2
`define MODE_STORE    2'h1
`define ST_FULL_BIT   0
`define ST_EVT_BIT    1
`define UPPER_RST     16'h0800
`define LOWER_RST     16'h0400
`define DELAY_RST     8'h08
`endif

// ===== logic/vgps_pkg.sv
// types shared by the voice gate, peak meter and speech store
package vgps_pkg;
  typedef enum logic [1:0] {G_OPEN, G_HOLD, G_FADE, G_SHUT} gate_state_e;
  typedef enum logic [1:0] {S_IDLE, S_REC, S_PLAY} store_state_e;
  typedef enum logic [3:0] {
    OP_NONE, OP_RESET, OP_ERASE, OP_PLAY, OP_PSTOP, OP_RESUME,
    OP_REC, OP_RSTOP, OP_STEPBACK, OP_QFREE, OP_QLEN, OP_QSTATE
  } store_op_e;
endpackage

// ===== logic/voice_gate_peak_and_store.sv
// top: register port, channel filters, peak meter, gate and speech store
//
// Summary of operation
// - largest sample magnitude of each 160-sample frame goes to peak result.
// - peak result updates only with its switch and control bit both on.
// - gate opens once a frame level reaches the upper threshold.
// - closing is judged against a lower threshold, giving hysteresis.
// - fade waits for the set count of quiet frames; louder ones restart it.
// - fade runs over 16 frames, one 6 dB step each, ending silent.
// - upper, lower, mute and shut delay are host registers.
// - both sample paths pass a channel filter limiting band to 4 kHz.
// - stored frames stay until erased, reset command or device reset.
// - at least 20 seconds of frames are always held for the store.
// - eight buffers, granted memory in 40-frame blocks while recording.
// - running out of blocks sets a memory-full status bit.
// - store runs by command and response words, mode, interrupt, status bit.
// - commands: reset, erase, play, stop, resume, record, stop, stepback.
// - play pointer kept on stop so resume carries on from there.
// - stepback moves the play pointer back by the given amount.
// - queries return free memory, buffer length or current state.
// - interrupt output rises only for status bits whose mask is set.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "vgps_consts.svh"
module voice_gate_peak_and_store
  import vgps_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // input voice path
  input  wire logic [15:0] mic_sample,
  input  wire logic        mic_valid,
  output logic      [15:0] enc_sample,
  output logic             enc_valid,
  // output voice path
  input  wire logic [15:0] dec_sample,
  input  wire logic        dec_valid,
  output logic      [15:0] spk_sample,
  output logic             spk_valid,
  // vocoded frames
  input  wire logic [15:0] rec_frame,
  input  wire logic        rec_valid,
  input  wire logic        play_req,
  output logic      [15:0] play_frame,
  output logic             play_valid,
  // host attention
  output logic             irq
);
  localparam logic [63:0] FIR_C = `FIR_COEFS;

  frame_if fi ();

  logic [15:0] tap_reg [2][`FIR_TAPS];
  logic [15:0] tap_next [2][`FIR_TAPS];
  logic [15:0] flt_reg [2];
  logic [15:0] flt_next [2];
  logic        fv_reg [2];
  logic        fv_next [2];
  logic [15:0] path_in [2];
  logic        path_vld [2];

  logic [15:0] ctrl_reg, ctrl_next;
  logic        pksw_reg, pksw_next;
  logic [15:0] up_reg, up_next;
  logic [15:0] lo_reg, lo_next;
  logic        mute_reg, mute_next;
  logic [7:0]  dly_reg, dly_next;
  logic [1:0]  ien_reg, ien_next;
  logic [1:0]  stat_reg, stat_next;
  logic [15:0] resp_reg, resp_next;
  logic [15:0] rd_reg, rd_next;
  logic        irq_reg, irq_next;
  logic [15:0] peak_val;

  store_state_e sst_reg, sst_next;
  logic [2:0]  cb_reg, cb_next;
  logic [9:0]  ptr_reg, ptr_next;
  logic [15:0] pf_reg, pf_next;
  logic        pv_reg, pv_next;
  logic [15:0] mem_reg [`MEM_WORDS];
  logic [15:0] mem_next [`MEM_WORDS];
  logic [9:0]  len_reg [`NUM_BUFS];
  logic [9:0]  len_next [`NUM_BUFS];
  logic [4:0]  btab_reg [`NUM_BUFS][`NUM_BLKS];
  logic [4:0]  btab_next [`NUM_BUFS][`NUM_BLKS];
  logic [2:0]  bown_reg [`NUM_BLKS];
  logic [2:0]  bown_next [`NUM_BLKS];
  logic [`NUM_BLKS-1:0] bused_reg, bused_next;

  logic        cmd_wr;
  store_op_e   cmd_op;
  logic [2:0]  cmd_buf;
  logic [9:0]  cmd_amt;
  logic [9:0]  cur_len;
  logic [4:0]  rec_blk, ply_blk;
  logic [5:0]  rec_off, ply_off;
  logic [5:0]  fres;
  logic [4:0]  free_cnt;

  function automatic logic [15:0] fir(input logic [15:0] t [`FIR_TAPS]);
    logic signed [23:0] acc;
    acc = 24'sh000000;
    for (int i = 0; i < `FIR_TAPS; i++)
      acc = acc + 24'($signed(t[i]) * $signed({1'b0, FIR_C[i*8 +: 8]}));
    return 16'(acc >>> `FIR_SHIFT);
  endfunction

  // memory location of frame off within a granted block
  function automatic logic [9:0] frame_addr(input logic [4:0] blk,
                                            input logic [5:0] off);
    return 10'({5'h00, blk} * {4'h0, `BLK_FRAMES}) + {4'h0, off};
  endfunction

  // lowest free block, bit 5 set when one exists
  function automatic logic [5:0] find_free(input logic [`NUM_BLKS-1:0] u);
    logic [5:0] r;
    r = 6'h00;
    for (int k = `NUM_BLKS - 1; k >= 0; k--)
      if (!u[k])
        r = {1'b1, 5'(k)};
    return r;
  endfunction

  assign path_in[0] = mic_sample;
  assign path_vld[0] = mic_valid;
  assign path_in[1] = dec_sample;
  assign path_vld[1] = dec_valid;

  // 7th-order low-pass on both directions
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      tap_next[p] = tap_reg[p];
      flt_next[p] = flt_reg[p];
      fv_next[p] = path_vld[p];
      if (path_vld[p])
      begin
        for (int i = `FIR_TAPS - 1; i > 0; i--)
          tap_next[p][i] = tap_reg[p][i-1];
        tap_next[p][0] = path_in[p];
        flt_next[p] = fir(tap_next[p]);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int p = 0; p < 2; p++)
      begin
        for (int i = 0; i < `FIR_TAPS; i++)
          tap_reg[p][i] <= 16'h0000;
        flt_reg[p] <= 16'h0000;
        fv_reg[p] <= 1'b0;
      end
    end
    else
    begin
      tap_reg <= tap_next;
      flt_reg <= flt_next;
      fv_reg <= fv_next;
    end
  end

  assign fi.sample = flt_reg[0];
  assign fi.valid = fv_reg[0];
  assign spk_sample = flt_reg[1];
  assign spk_valid = fv_reg[1];

  peak_meter u_peak (
    .mclk        (mclk),
    .rst         (rst),
    .enable      (pksw_reg && ctrl_reg[`CTRL_PEAK_BIT]),
    .fi          (fi),
    .peak_result (peak_val)
  );

  noise_gate u_gate (
    .mclk       (mclk),
    .rst        (rst),
    .fi         (fi),
    .upper      (up_reg),
    .lower      (lo_reg),
    .mute       (mute_reg),
    .shut_delay (dly_reg),
    .out_sample (enc_sample),
    .out_valid  (enc_valid)
  );

  // commands act only in store mode so a stray write cannot disturb speech
  assign cmd_wr = reg_wr && reg_addr == `OFS_CMD
                  && ctrl_reg[1:0] == `MODE_STORE;
  assign cmd_op = store_op_e'(reg_wdata[15:12]);
  assign cmd_buf = reg_wdata[11:9];
  assign cmd_amt = {1'b0, reg_wdata[8:0]};
  assign cur_len = len_reg[cb_reg];
  assign rec_blk = 5'(cur_len / {4'h0, `BLK_FRAMES});
  assign rec_off = 6'(cur_len % {4'h0, `BLK_FRAMES});
  assign ply_blk = 5'(ptr_reg / {4'h0, `BLK_FRAMES});
  assign ply_off = 6'(ptr_reg % {4'h0, `BLK_FRAMES});
  assign fres = find_free(bused_reg);

  always_comb
  begin
    free_cnt = 5'h00;
    for (int k = 0; k < `NUM_BLKS; k++)
      free_cnt = free_cnt + {4'h0, !bused_reg[k]};
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    pksw_next = pksw_reg;
    up_next = up_reg;
    lo_next = lo_reg;
    mute_next = mute_reg;
    dly_next = dly_reg;
    ien_next = ien_reg;
    stat_next = stat_reg;
    resp_next = resp_reg;
    rd_next = 16'h0000;
    irq_next = |(stat_reg & ien_reg);
    sst_next = sst_reg;
    cb_next = cb_reg;
    ptr_next = ptr_reg;
    pf_next = pf_reg;
    pv_next = 1'b0;
    mem_next = mem_reg;
    len_next = len_reg;
    btab_next = btab_reg;
    bown_next = bown_reg;
    bused_next = bused_reg;
    if (reg_rd)
      case (reg_addr)
        `OFS_CTRL:   rd_next = ctrl_reg;
        `OFS_PKSW:   rd_next = {15'h0000, pksw_reg};
        `OFS_PEAK:   rd_next = peak_val;
        `OFS_UPPER:  rd_next = up_reg;
        `OFS_LOWER:  rd_next = lo_reg;
        `OFS_MUTE:   rd_next = {15'h0000, mute_reg};
        `OFS_DELAY:  rd_next = {8'h00, dly_reg};
        `OFS_RESP:   rd_next = resp_reg;
        `OFS_STATUS: rd_next = {14'h0000, stat_reg};
        `OFS_IEN:    rd_next = {14'h0000, ien_reg};
        default:     rd_next = 16'h0000;
      endcase
    if (reg_wr)
      case (reg_addr)
        `OFS_CTRL:   ctrl_next = reg_wdata;
        `OFS_PKSW:   pksw_next = reg_wdata[0];
        `OFS_UPPER:  up_next = reg_wdata;
        `OFS_LOWER:  lo_next = reg_wdata;
        `OFS_MUTE:   mute_next = reg_wdata[0];
        `OFS_DELAY:  dly_next = reg_wdata[7:0];
        `OFS_STATUS: stat_next = stat_reg & ~reg_wdata[1:0];
        `OFS_IEN:    ien_next = reg_wdata[1:0];
        default:     ctrl_next = ctrl_reg;
      endcase
    // events below follow the status clear, so a same-cycle set wins
    if (rec_valid && sst_reg == S_REC)
    begin
      if (rec_off != 6'h00)
      begin
        mem_next[frame_addr(btab_reg[cb_reg][rec_blk], rec_off)] = rec_frame;
        len_next[cb_reg] = cur_len + 10'h001;
      end
      else if (fres[5])
      begin
        bused_next[fres[4:0]] = 1'b1;
        bown_next[fres[4:0]] = cb_reg;
        btab_next[cb_reg][rec_blk] = fres[4:0];
        mem_next[frame_addr(fres[4:0], 6'h00)] = rec_frame;
        len_next[cb_reg] = cur_len + 10'h001;
      end
      else
      begin
        stat_next[`ST_FULL_BIT] = 1'b1;
        stat_next[`ST_EVT_BIT] = 1'b1;
        sst_next = S_IDLE;
      end
    end
    if (play_req && sst_reg == S_PLAY)
    begin
      if (ptr_reg < cur_len)
      begin
        pf_next = mem_reg[frame_addr(btab_reg[cb_reg][ply_blk], ply_off)];
        pv_next = 1'b1;
        ptr_next = ptr_reg + 10'h001;
      end
      else
      begin
        sst_next = S_IDLE;
        stat_next[`ST_EVT_BIT] = 1'b1;
      end
    end
    if (cmd_wr)
      case (cmd_op)
        OP_RESET:
        begin
          bused_next = '0;
          for (int b = 0; b < `NUM_BUFS; b++)
            len_next[b] = 10'h000;
          sst_next = S_IDLE;
          ptr_next = 10'h000;
        end
        OP_ERASE, OP_REC:
        begin
          for (int k = 0; k < `NUM_BLKS; k++)
            if (bused_reg[k] && bown_reg[k] == cmd_buf)
              bused_next[k] = 1'b0;
          len_next[cmd_buf] = 10'h000;
          if (cmd_op == OP_REC)
          begin
            cb_next = cmd_buf;
            sst_next = S_REC;
            ptr_next = 10'h000;
          end
          else if (cb_reg == cmd_buf)
          begin
            sst_next = S_IDLE;
            ptr_next = 10'h000;
          end
        end
        OP_PLAY:
        begin
          cb_next = cmd_buf;
          ptr_next = 10'h000;
          sst_next = S_PLAY;
        end
        OP_PSTOP:
          if (sst_reg == S_PLAY)
            sst_next = S_IDLE;
        OP_RESUME:
          sst_next = S_PLAY;
        OP_RSTOP:
          if (sst_reg == S_REC)
            sst_next = S_IDLE;
        OP_STEPBACK:
          ptr_next = (ptr_reg >= cmd_amt) ? ptr_reg - cmd_amt : 10'h000;
        OP_QFREE:
          resp_next = 16'({11'h000, free_cnt} * {10'h000, `BLK_FRAMES});
        OP_QLEN:
          resp_next = {6'h00, len_reg[cmd_buf]};
        OP_QSTATE:
          resp_next = {14'h0000, sst_reg};
        default:
          resp_next = resp_reg;
      endcase
  end

  // fixed store of 25 blocks of 40 frames is never lent out
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= 16'h0000;
      pksw_reg <= 1'b0;
      up_reg <= `UPPER_RST;
      lo_reg <= `LOWER_RST;
      mute_reg <= 1'b0;
      dly_reg <= `DELAY_RST;
      ien_reg <= 2'h0;
      stat_reg <= 2'h0;
      resp_reg <= 16'h0000;
      rd_reg <= 16'h0000;
      irq_reg <= 1'b0;
      sst_reg <= S_IDLE;
      cb_reg <= 3'h0;
      ptr_reg <= 10'h000;
      pf_reg <= 16'h0000;
      pv_reg <= 1'b0;
      bused_reg <= '0;
      for (int b = 0; b < `NUM_BUFS; b++)
        len_reg[b] <= 10'h000;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      pksw_reg <= pksw_next;
      up_reg <= up_next;
      lo_reg <= lo_next;
      mute_reg <= mute_next;
      dly_reg <= dly_next;
      ien_reg <= ien_next;
      stat_reg <= stat_next;
      resp_reg <= resp_next;
      rd_reg <= rd_next;
      irq_reg <= irq_next;
      sst_reg <= sst_next;
      cb_reg <= cb_next;
      ptr_reg <= ptr_next;
      pf_reg <= pf_next;
      pv_reg <= pv_next;
      bused_reg <= bused_next;
      len_reg <= len_next;
    end
  end

  // speech words need no reset: lengths and block map gate every read
  always_ff @(posedge mclk)
  begin
    mem_reg <= mem_next;
    btab_reg <= btab_next;
    bown_reg <= bown_next;
  end

  assign reg_rdata = rd_reg;
  assign irq = irq_reg;
  assign play_frame = pf_reg;
  assign play_valid = pv_reg;

  property p_irq_mask;
    @(posedge mclk) disable iff (rst)
      ((stat_reg & ien_reg) == 2'h0) |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised without an enabled status bit");

  property p_read_slot;
    @(posedge mclk) disable iff (rst)
      (reg_rd && reg_addr == `OFS_UPPER) |=> reg_rdata == $past(up_reg);
  endproperty
  a_read_slot: assert property (p_read_slot)
    else $error("upper threshold read back wrong");

  property p_resume;
    @(posedge mclk) disable iff (rst)
      (cmd_wr && cmd_op == OP_RESUME && !play_req)
        |=> (sst_reg == S_PLAY && ptr_reg == $past(ptr_reg));
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume lost the play position");

  property p_stepback;
    @(posedge mclk) disable iff (rst)
      (cmd_wr && cmd_op == OP_STEPBACK && ptr_reg >= cmd_amt)
        |=> ptr_reg == $past(ptr_reg) - $past(cmd_amt);
  endproperty
  a_stepback: assert property (p_stepback)
    else $error("stepback moved pointer by wrong amount");

  property p_full;
    @(posedge mclk) disable iff (rst)
      (rec_valid && sst_reg == S_REC && rec_off == 6'h00 && !fres[5]
       && !cmd_wr) |=> (stat_reg[`ST_FULL_BIT] && sst_reg == S_IDLE);
  endproperty
  a_full: assert property (p_full)
    else $error("memory exhaustion not flagged");
endmodule
